// ==== rtl/adc_conversion_trigger_control.sv ====
// Summary of operation
// - a compare start is taken only with compare mode bits 1011 and the converter on.
// - a trigger sets the go flag and clears the selected timer counter.
// - with the converter off the trigger is ignored but still clears the timer.
// - the result pair is readable in the instruction cycle after completion.
// - the return to sampling happens on the next Q4 phase after conversion ends.
// - the bit period is the device clock divided by the software-selected divider.
// - clearing go during a conversion aborts it and keeps the old result.
// - after an abort the block waits two bit periods then resumes acquisition.
module adc_conversion_trigger_control
  import conv_pkg::*;
#(
  parameter int DIV_WIDTH = 7
)(
  input  wire logic       MCLK_IN,
  input  wire logic       RST_IN,
  input  wire logic [3:0] ADDR_IN,
  input  wire logic [7:0] WDATA_IN,
  input  wire logic       WR_IN,
  input  wire logic       RD_IN,
  output logic      [7:0] RDATA_OUT,
  input  wire logic [3:0] COMPARE_B_MODE_BITS_IN,
  input  wire logic       SPECIAL_TRIGGER_IN,
  input  wire logic       COMPARATOR_HIGH_IN,
  output logic            TIMER_CLEAR_OUT,
  output logic            SAMPLE_CONNECT_OUT,
  output logic      [3:0] CHANNEL_OUT,
  output logic            IRQ_OUT
);
  reg_req_s          req;
  logic        [7:0] channel_go_r;
  logic        [7:0] ref_port_r;
  logic        [7:0] format_clock_r;
  logic        [7:0] irq_flags_r;
  logic        [7:0] irq_enables_r;
  logic        [7:0] irq_priority_r;
  logic        [7:0] result_high_r;
  logic        [7:0] result_low_r;
  logic        [7:0] rdata_r;
  logic        [9:0] sar_r;
  logic        [9:0] sar_nxt;
  logic        [3:0] bit_cnt_r;
  logic [DIV_WIDTH-1:0] div_cnt_r;
  logic [DIV_WIDTH-1:0] div_limit;
  logic        [1:0] phase_r;
  logic              tad_tick;
  logic              comp_sync1_r;
  logic              comp_sync2_r;
  logic              trig_sync1_r;
  logic              trig_sync2_r;
  logic              trig_prev_r;
  logic              trig_pulse;
  logic              trig_start;
  logic              sample_r;
  logic              go_wr_set;
  logic              go_wr_clr;
  logic              done;
  logic              abort;
  conv_state_e       state_r;

  assign req = '{addr: ADDR_IN, wdata: WDATA_IN, wr: WR_IN, rd: RD_IN};

  // comparator and trigger come from outside this clock: two flops each
  always_ff @(posedge MCLK_IN)
  begin
    if (RST_IN)
    begin
      comp_sync1_r <= 1'b0;
      comp_sync2_r <= 1'b0;
      trig_sync1_r <= 1'b0;
      trig_sync2_r <= 1'b0;
      trig_prev_r  <= 1'b0;
    end
    else
    begin
      comp_sync1_r <= COMPARATOR_HIGH_IN;
      comp_sync2_r <= comp_sync1_r;
      trig_sync1_r <= SPECIAL_TRIGGER_IN;
      trig_sync2_r <= trig_sync1_r;
      trig_prev_r  <= trig_sync2_r;
    end
  end

  assign trig_pulse = trig_sync2_r && !trig_prev_r
                      && (COMPARE_B_MODE_BITS_IN == TRIGGER_MODE);
  // timer clears even when the converter is off
  assign TIMER_CLEAR_OUT = trig_pulse;
  assign trig_start = trig_pulse && channel_go_r[CONVERTER_ON_BIT];

  // q phases of the device clock: four MCLK edges make one instruction cycle
  always_ff @(posedge MCLK_IN)
  begin
    if (RST_IN)
      phase_r <= 2'h0;
    else
      phase_r <= phase_r + 2'h1;
  end

  // bit period: divider select n gives 2^(n+1) clocks; longest wins on overflow
  always_comb
  begin
    div_limit = '1;
    if (int'(format_clock_r[2:0]) + 1 < DIV_WIDTH)
      div_limit = DIV_WIDTH'((1 << (int'(format_clock_r[2:0]) + 1)) - 1);
  end

  always_ff @(posedge MCLK_IN)
  begin
    // restart on abort so the wait that follows is two whole bit periods
    if (RST_IN || state_r == IDLE || state_r == SWITCHBACK || abort)
      div_cnt_r <= '0;
    else if (div_cnt_r >= div_limit)
      div_cnt_r <= '0;
    else
      div_cnt_r <= div_cnt_r + 1'b1;
  end
  assign tad_tick = (div_cnt_r >= div_limit);

  assign go_wr_set = req.wr && req.addr == REG_CHANNEL_GO && req.wdata[GO_BIT];
  assign go_wr_clr = req.wr && req.addr == REG_CHANNEL_GO && !req.wdata[GO_BIT];

  // successive approximation: trial bit kept when the comparator says input is higher
  always_comb
  begin
    sar_nxt = sar_r;
    if (!comp_sync2_r && bit_cnt_r != 4'h0)
      sar_nxt[bit_cnt_r - 4'h1] = 1'b0;
    if (bit_cnt_r > 4'h1)
      sar_nxt[bit_cnt_r - 4'h2] = 1'b1;
  end

  // a software clear of go or the converter turned off both end a running conversion
  assign abort = state_r == CONVERT && (go_wr_clr || !channel_go_r[CONVERTER_ON_BIT]);
  assign done = state_r == CONVERT && tad_tick && bit_cnt_r == 4'h1 && !abort;

  always_ff @(posedge MCLK_IN)
  begin
    if (RST_IN)
    begin
      state_r   <= IDLE;
      bit_cnt_r <= 4'h0;
      sar_r     <= 10'h000;
      sample_r  <= 1'b1;
    end
    else
    begin
      unique case (state_r)
        IDLE:
        begin
          if (channel_go_r[GO_BIT] && channel_go_r[CONVERTER_ON_BIT])
          begin
            state_r   <= CONVERT;
            bit_cnt_r <= RESULT_BITS;
            sar_r     <= 10'h200;
            sample_r  <= 1'b0;
          end
        end
        CONVERT:
        begin
          if (go_wr_clr || !channel_go_r[CONVERTER_ON_BIT])
          begin
            state_r   <= ABORT_WAIT;
            bit_cnt_r <= ABORT_WAIT_PERIODS;
          end
          else if (tad_tick)
          begin
            sar_r     <= sar_nxt;
            bit_cnt_r <= bit_cnt_r - 4'h1;
            if (bit_cnt_r == 4'h1)
              state_r <= SWITCHBACK;
          end
        end
        SWITCHBACK:
        begin
          if (phase_r == LAST_PHASE)
          begin
            sample_r <= 1'b1;
            state_r  <= IDLE;
          end
        end
        ABORT_WAIT:
        begin
          if (tad_tick)
          begin
            bit_cnt_r <= bit_cnt_r - 4'h1;
            if (bit_cnt_r == 4'h1)
            begin
              sample_r <= 1'b1;
              state_r  <= IDLE;
            end
          end
        end
      endcase
    end
  end

  // control registers; hardware set of go wins over nothing, done clear wins over trigger
  always_ff @(posedge MCLK_IN)
  begin
    if (RST_IN)
    begin
      channel_go_r   <= CHANNEL_GO_RST;
      ref_port_r     <= REF_PORT_RST;
      format_clock_r <= FORMAT_CLOCK_RST;
      irq_enables_r  <= IRQ_ENABLES_RST;
      irq_priority_r <= IRQ_PRIORITY_RST;
    end
    else
    begin
      if (req.wr && req.addr == REG_CHANNEL_GO)
        channel_go_r <= {2'b00, req.wdata[5:0]};
      if (req.wr && req.addr == REG_REF_PORT)
        ref_port_r <= {2'b00, req.wdata[5:0]};
      if (req.wr && req.addr == REG_FORMAT_CLOCK)
        format_clock_r <= {req.wdata[7], 4'h0, req.wdata[2:0]};
      if (req.wr && req.addr == REG_IRQ_ENABLES)
        irq_enables_r <= req.wdata;
      if (req.wr && req.addr == REG_IRQ_PRIORITY)
        irq_priority_r <= req.wdata;
      if (done)
        channel_go_r[GO_BIT] <= 1'b0;
      else if (trig_start && !go_wr_clr)
        channel_go_r[GO_BIT] <= 1'b1;
      else if (state_r == CONVERT && !channel_go_r[CONVERTER_ON_BIT])
        channel_go_r[GO_BIT] <= 1'b0;
    end
  end

  // result loads in the same edge as done, so the next cycle reads it; aborts leave it
  always_ff @(posedge MCLK_IN)
  begin
    if (RST_IN)
    begin
      result_high_r <= RESULT_RST;
      result_low_r  <= RESULT_RST;
    end
    else if (done)
    begin
      if (format_clock_r[JUSTIFY_BIT])
      begin
        result_high_r <= {6'h00, sar_nxt[9:8]};
        result_low_r  <= sar_nxt[7:0];
      end
      else
      begin
        result_high_r <= sar_nxt[9:2];
        result_low_r  <= {sar_nxt[1:0], 6'h00};
      end
    end
    else
    begin
      if (req.wr && req.addr == REG_RESULT_HIGH)
        result_high_r <= req.wdata;
      if (req.wr && req.addr == REG_RESULT_LOW)
        result_low_r <= req.wdata;
    end
  end

  // flags clear on a read of the flag register, but a same-cycle event survives
  always_ff @(posedge MCLK_IN)
  begin
    if (RST_IN)
      irq_flags_r <= IRQ_FLAGS_RST;
    else
    begin
      if (req.rd && req.addr == REG_IRQ_FLAGS)
        irq_flags_r <= 8'h00;
      else if (req.wr && req.addr == REG_IRQ_FLAGS)
        irq_flags_r <= req.wdata;
      if (done)
        irq_flags_r[DONE_FLAG_BIT] <= 1'b1;
    end
  end

  always_ff @(posedge MCLK_IN)
  begin
    if (RST_IN)
      rdata_r <= 8'h00;
    else if (req.rd)
    begin
      unique case (req.addr)
        REG_RESULT_HIGH:  rdata_r <= result_high_r;
        REG_RESULT_LOW:   rdata_r <= result_low_r;
        REG_CHANNEL_GO:   rdata_r <= channel_go_r;
        REG_REF_PORT:     rdata_r <= ref_port_r;
        REG_FORMAT_CLOCK: rdata_r <= format_clock_r;
        REG_IRQ_FLAGS:    rdata_r <= irq_flags_r;
        REG_IRQ_ENABLES:  rdata_r <= irq_enables_r;
        REG_IRQ_PRIORITY: rdata_r <= irq_priority_r;
        default:          rdata_r <= 8'h00;
      endcase
    end
    else
      rdata_r <= 8'h00;
  end

  assign RDATA_OUT          = rdata_r;
  assign SAMPLE_CONNECT_OUT = sample_r;
  assign CHANNEL_OUT        = channel_go_r[CHANNEL_LSB +: 4];
  assign IRQ_OUT            = |(irq_flags_r & irq_enables_r);
endmodule : adc_conversion_trigger_control

// ==== rtl/conv_pkg.sv ====
package conv_pkg;
  // register indices on the plain register port
  localparam logic [3:0] REG_RESULT_HIGH  = 4'h0;
  localparam logic [3:0] REG_RESULT_LOW   = 4'h1;
  localparam logic [3:0] REG_CHANNEL_GO   = 4'h2;
  localparam logic [3:0] REG_REF_PORT     = 4'h3;
  localparam logic [3:0] REG_FORMAT_CLOCK = 4'h4;
  localparam logic [3:0] REG_IRQ_FLAGS    = 4'h5;
  localparam logic [3:0] REG_IRQ_ENABLES  = 4'h6;
  localparam logic [3:0] REG_IRQ_PRIORITY = 4'h7;
  // field positions
  localparam int CONVERTER_ON_BIT = 0;
  localparam int GO_BIT           = 1;
  localparam int CHANNEL_LSB      = 2;
  localparam int JUSTIFY_BIT      = 7;
  localparam int DONE_FLAG_BIT    = 6;
  // reset values
  localparam logic [7:0] CHANNEL_GO_RST    = 8'h00;
  localparam logic [7:0] REF_PORT_RST      = 8'h00;
  localparam logic [7:0] FORMAT_CLOCK_RST  = 8'h00;
  localparam logic [7:0] IRQ_FLAGS_RST     = 8'h00;
  localparam logic [7:0] IRQ_ENABLES_RST   = 8'h00;
  localparam logic [7:0] IRQ_PRIORITY_RST  = 8'h7f;
  localparam logic [7:0] RESULT_RST        = 8'h00;
  // compare mode pattern for the special event trigger
  localparam logic [3:0] TRIGGER_MODE      = 4'hb;
  // conversion timing in bit periods
  localparam logic [3:0] RESULT_BITS       = 4'ha;
  localparam logic [3:0] ABORT_WAIT_PERIODS = 4'h2;
  // last device clock phase (Q4) of an instruction cycle
  localparam logic [1:0] LAST_PHASE        = 2'h3;

  typedef enum logic [1:0] {IDLE, CONVERT, SWITCHBACK, ABORT_WAIT} conv_state_e;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_s;
endpackage : conv_pkg

// ==== testbench/adc_ctl_checker.sv ====
module adc_ctl_checker
  import conv_pkg::*;
#(
  parameter int DIV_WIDTH = 7
)(
  input wire logic       MCLK_IN,
  input wire logic       RST_IN,
  input wire logic [3:0] ADDR_IN,
  input wire logic [7:0] WDATA_IN,
  input wire logic       WR_IN,
  input wire logic       RD_IN,
  input wire logic [7:0] RDATA_OUT,
  input wire logic [3:0] COMPARE_B_MODE_BITS_IN,
  input wire logic       SPECIAL_TRIGGER_IN,
  input wire logic       TIMER_CLEAR_OUT,
  input wire logic       SAMPLE_CONNECT_OUT,
  input wire logic [3:0] CHANNEL_OUT
);
  timeunit 1ns;
  timeprecision 1ns;
  // longest busy stretch: ten periods of the slowest divider plus an abort wait
  localparam int CONV_MAX = 12 * (1 << DIV_WIDTH) + 8;
  int low_cycles;
  always_ff @(posedge MCLK_IN)
  begin
    if (RST_IN || SAMPLE_CONNECT_OUT)
      low_cycles <= 0;
    else
      low_cycles <= low_cycles + 1;
  end
  default clocking cb @(posedge MCLK_IN);
  endclocking
  default disable iff (RST_IN);
  sequence conv_start_s;
    $fell(SAMPLE_CONNECT_OUT);
  endsequence
  sequence conv_hold_s;
    !SAMPLE_CONNECT_OUT [*4];
  endsequence
  chk_read_idle: assert property (!RD_IN |=> RDATA_OUT == 8'h00)
    else $error("read data not idle");
  chk_unmapped_zero: assert property (RD_IN && ADDR_IN[3] |=> RDATA_OUT == 8'h00)
    else $error("unmapped read not zero");
  chk_clear_mode: assert property (TIMER_CLEAR_OUT |-> COMPARE_B_MODE_BITS_IN == TRIGGER_MODE)
    else $error("timer clear outside trigger mode");
  chk_clear_cause: assert property (TIMER_CLEAR_OUT |-> $past(SPECIAL_TRIGGER_IN, 2))
    else $error("timer clear without trigger");
  chk_clear_pulse: assert property (TIMER_CLEAR_OUT |=> !TIMER_CLEAR_OUT)
    else $error("timer clear longer than one cycle");
  chk_conv_min: assert property (conv_start_s |-> conv_hold_s)
    else $error("conversion too short");
  chk_conv_end: assert property (low_cycles <= CONV_MAX)
    else $error("sampling not restored");
  chk_chan_load: assert property (WR_IN && ADDR_IN == REG_CHANNEL_GO |=>
    {2'b00, CHANNEL_OUT, 2'b00} == ($past(WDATA_IN) & 8'h3c))
    else $error("channel not loaded");
  chk_chan_hold: assert property (!(WR_IN && ADDR_IN == REG_CHANNEL_GO) |=> $stable(CHANNEL_OUT))
    else $error("channel changed without write");
endmodule : adc_ctl_checker

// ==== testbench/test_adc_conversion_trigger_control.sv ====
module test_adc_conversion_trigger_control
  import conv_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, fire = 1'b0, lvl = 1'b0;
  logic [3:0] addr = 4'h0, mode = 4'h0, chan, ch, md;
  logic [7:0] wdata = 8'h00, rdata;
  logic       tclr, samp, irq, trig, cmp, on, en, rj, go, l;
  logic [1:0] sel;
  int         clears, bad_count = 0, tests_run = 0, cyc = 0, i, n, len, hi = 0, lo = 0;
  logic [7:0] rst_tab[10] = '{RESULT_RST, RESULT_RST, CHANNEL_GO_RST, REF_PORT_RST,
    FORMAT_CLOCK_RST, IRQ_FLAGS_RST, IRQ_ENABLES_RST, IRQ_PRIORITY_RST, 8'h00, 8'h00};
  always #20 clk = ~clk;
  adc_conversion_trigger_control #(.DIV_WIDTH(7)) adc_conversion_trigger_control_inst (
    .MCLK_IN(clk), .RST_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd),
    .RDATA_OUT(rdata), .COMPARE_B_MODE_BITS_IN(mode), .SPECIAL_TRIGGER_IN(trig),
    .COMPARATOR_HIGH_IN(cmp), .TIMER_CLEAR_OUT(tclr), .SAMPLE_CONNECT_OUT(samp),
    .CHANNEL_OUT(chan), .IRQ_OUT(irq));
  trig_partner trig_partner_inst (.clk_in(clk), .rst_in(rst), .fire_in(fire), .level_in(lvl),
    .clear_in(tclr), .trig_out(trig), .cmp_out(cmp), .clears_out(clears));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      bad_count++;
      end_sim();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wreg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  task automatic rchk(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, v);
  endtask : rchk
  initial
  begin
    void'($urandom(89482));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 10; i++)
      rchk(4'(i), rst_tab[i]);
    wreg(REG_REF_PORT, 8'h5a);
    rchk(REG_REF_PORT, 8'h1a); // bits 7:6 are unimplemented and read as zero
    for (i = 0; i < 8; i++)
    begin
      sel = 2'($urandom_range(2));
      rj = 1'($urandom_range(1));
      en = 1'($urandom_range(1));
      l = 1'($urandom_range(1));
      ch = 4'($urandom);
      md = (i < 2 || $urandom_range(1)) ? TRIGGER_MODE : 4'($urandom_range(10));
      on = (i != 1);
      go = on && md == TRIGGER_MODE;
      wreg(REG_FORMAT_CLOCK, {rj, 5'h00, sel});
      wreg(REG_IRQ_ENABLES, {1'b0, en, 6'h00});
      wreg(REG_CHANNEL_GO, {2'b00, ch, 1'b0, on});
      mode <= md;
      lvl <= l;
      repeat (20) @(posedge clk);
      n = clears;
      chk(chan, ch);
      fire <= 1'b1;
      @(posedge clk);
      fire <= 1'b0;
      repeat (8) @(posedge clk);
      #1;
      chk(16'(clears), 16'(n + (md == TRIGGER_MODE)));
      chk(samp, !go);
      if (go)
      begin
        len = 0;
        while (!samp && len < 500)
        begin
          @(posedge clk);
          #1;
          len++;
        end
        chk(len >= (20 << sel) - 8 && len <= (24 << sel) + 16, 1'b1);
        hi = rj ? (l ? 3 : 0) : (l ? 255 : 0);
        lo = rj ? (l ? 255 : 0) : (l ? 192 : 0);
        @(posedge clk);
        #1;
        chk(irq, en);
        rchk(REG_IRQ_FLAGS, 8'h40);
        chk(irq, 1'b0);
      end
      else
        rchk(REG_IRQ_FLAGS, 8'h00);
      rchk(REG_RESULT_HIGH, 8'(hi));
      rchk(REG_RESULT_LOW, 8'(lo));
    end
    // converter on first, go in a later write
    wreg(REG_FORMAT_CLOCK, 8'h02);
    wreg(REG_CHANNEL_GO, 8'h01);
    wreg(REG_CHANNEL_GO, 8'h03);
    repeat (6) @(posedge clk);
    #1;
    chk(samp, 1'b0);
    wreg(REG_CHANNEL_GO, 8'h01);
    repeat (12) @(posedge clk);
    #1;
    chk(samp, 1'b0);
    repeat (18) @(posedge clk);
    #1;
    chk(samp, 1'b1);
    rchk(REG_IRQ_FLAGS, 8'h00);
    rchk(REG_RESULT_HIGH, 8'(hi));
    rchk(REG_RESULT_LOW, 8'(lo));
    end_sim();
  end
endmodule : test_adc_conversion_trigger_control
bind adc_conversion_trigger_control adc_ctl_checker #(.DIV_WIDTH(DIV_WIDTH)) adc_ctl_checker_inst (
  .MCLK_IN, .RST_IN, .ADDR_IN, .WDATA_IN, .WR_IN, .RD_IN, .RDATA_OUT, .COMPARE_B_MODE_BITS_IN,
  .SPECIAL_TRIGGER_IN, .TIMER_CLEAR_OUT, .SAMPLE_CONNECT_OUT, .CHANNEL_OUT);

// ==== testbench/trig_partner.sv ====
module trig_partner (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic fire_in,
  input  wire logic level_in,
  input  wire logic clear_in,
  output logic      trig_out,
  output logic      cmp_out,
  output int        clears_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] hold_r;
  // trigger held several cycles so the two-flop sync cannot miss it
  always_ff @(posedge clk_in)
  begin
    if (rst_in || fire_in)
      hold_r <= rst_in ? 3'h0 : 3'h4;
    else if (hold_r != 3'h0)
      hold_r <= hold_r - 3'h1;
  end
  assign trig_out = hold_r != 3'h0;
  // the timer itself is reduced to a count of its clears
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      clears_out <= 0;
    else if (clear_in)
      clears_out <= clears_out + 1;
  end
  assign cmp_out = level_in;
endmodule : trig_partner
